// ---- lpr_result_regs.sv ----
// Result register bank with two-wire serial slave and emitter control
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Ambient light is a 16-bit result in bytes at 85h and 86h.
// RULE_02: 85h reads ambient bits 15:8 and ignores writes.
// RULE_03: 86h reads ambient bits 7:0 and ignores writes.
// RULE_04: Proximity is a 16-bit result in bytes at 87h and 88h.
// RULE_05: 87h reads proximity bits 15:8 and ignores writes.
// RULE_06: 88h reads proximity bits 7:0 and ignores writes.
// RULE_07: 89h holds a two-bit writable frequency code in bits 1:0.
// RULE_08: During proximity measurement the emitter gets a square wave.
// RULE_09: Codes 00..11 give 3.125, 1.5625, 0.78125, 0.390625 MHz.
// RULE_10: The frequency code is 10 after reset.
// RULE_11: The host writes the register address, then reads after a start.
// RULE_12: The register pointer advances after every byte read.
// RULE_13: Both bytes of a result are replaced together.
// RULE_14: Bits 7:2 of the frequency register read zero and drop writes.
module lpr_result_regs
    import lpr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire lpr_meas_s amb_meas,
    input wire lpr_meas_s prox_meas,
    input wire logic prox_active,
    output logic ir_drive,
    output logic [1:0] freq_sel
);
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    lpr_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shreg_ff, nxt_shreg;
    logic [7:0] tx_ff, nxt_tx;
    logic [7:0] ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw;
    logic mack_ff, nxt_mack;
    logic oe_ff, nxt_oe;
    logic sda_out_ff;
    logic [FREQ_W-1:0] freq_ff;
    logic [15:0] res_ff [N_CH];
    lpr_meas_s meas_w [N_CH];
    logic [7:0] rd_byte;
    logic hit_amb_hi, hit_amb_lo, hit_prox_hi, hit_prox_lo, hit_freq;
    logic byte_in, wr_stb;

    // Two-stage synchronisers; the third stage is only for edge finding
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_s1_ff <= scl;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff <= sda_s2_ff;
        end
    end

    // Bus events seen on the synchronised lines
    assign scl_rise = scl_s2_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s2_ff & scl_d_ff;
    assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    assign bus_stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
    assign byte_in = scl_fall & (cnt_ff == BITS_BYTE);
    assign wr_stb = (state_ff == ST_WDATA) & byte_in;

    // Register address decode
    assign hit_amb_hi = (ptr_ff == REG_AMB_HI);
    assign hit_amb_lo = (ptr_ff == REG_AMB_LO);
    assign hit_prox_hi = (ptr_ff == REG_PROX_HI);
    assign hit_prox_lo = (ptr_ff == REG_PROX_LO);
    assign hit_freq = (ptr_ff == REG_FREQ);

    // Read data select; unmapped addresses read zero
    assign rd_byte =
        hit_amb_hi ? res_ff[CH_AMB][15:8] :   // [RULE_01] [RULE_02]
        hit_amb_lo ? res_ff[CH_AMB][7:0] :    // [RULE_03]
        hit_prox_hi ? res_ff[CH_PROX][15:8] : // [RULE_04] [RULE_05]
        hit_prox_lo ? res_ff[CH_PROX][7:0] :  // [RULE_06]
        hit_freq ? {6'h00, freq_ff} :         // [RULE_07] [RULE_14]
        RD_NONE;

    assign meas_w[CH_AMB] = amb_meas;
    assign meas_w[CH_PROX] = prox_meas;

    // Result storage: the whole word moves at once, so a high byte and
    // the low byte read after it come from one measurement, unless a new
    // result lands between the two reads. Reset clears both words to zero.
    generate
        for (genvar ch = 0; ch < N_CH; ch++) begin : g_res
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    res_ff[ch] <= 16'h0000;
                end else if (meas_w[ch].valid) begin
                    res_ff[ch] <= meas_w[ch].value; // [RULE_13]
                end
            end
        end
    endgenerate

    // Frequency code; only bits 1:0 of a write are kept
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freq_ff <= FREQ_RST; // [RULE_10]
        end else if (wr_stb && hit_freq) begin
            freq_ff <= shreg_ff[FREQ_LSB +: FREQ_W]; // [RULE_07] [RULE_14]
        end
    end

    // Serial slave next state; bits are taken on SCL rise and driven on
    // SCL fall. No clock stretching: a read byte is fetched on the fall
    // that starts it, which leaves a full low phase for setup.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_shreg = shreg_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_mack = mack_ff;
        nxt_oe = oe_ff;
        case (state_ff)
            ST_ADDR, ST_REG, ST_WDATA: begin
                if (scl_rise) begin
                    nxt_shreg = {shreg_ff[6:0], sda_s2_ff};
                    nxt_cnt = cnt_ff + 4'h1;
                end else if (byte_in) begin
                    nxt_cnt = 4'h0;
                    nxt_oe = 1'b1;
                    if (state_ff == ST_ADDR) begin
                        nxt_rw = shreg_ff[0];
                        nxt_state = ST_ADDR_ACK;
                        if (shreg_ff[7:1] != DEV_ADDR) begin
                            nxt_oe = 1'b0;
                            nxt_state = ST_IDLE;
                        end
                    end else if (state_ff == ST_REG) begin
                        nxt_ptr = shreg_ff; // [RULE_11]
                        nxt_state = ST_REG_ACK;
                    end else begin
                        nxt_ptr = ptr_ff + 8'h01;
                        nxt_state = ST_WDATA_ACK;
                    end
                end
            end
            ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
                if (scl_fall) begin
                    nxt_oe = 1'b0;
                    nxt_state = (state_ff == ST_ADDR_ACK) ? ST_REG : ST_WDATA;
                    if (state_ff == ST_ADDR_ACK && rw_ff) begin
                        nxt_tx = rd_byte;
                        nxt_oe = ~rd_byte[7];
                        nxt_ptr = ptr_ff + 8'h01; // [RULE_12]
                        nxt_state = ST_RDATA;
                    end
                end
            end
            ST_RDATA: begin
                if (scl_fall) begin
                    nxt_cnt = cnt_ff + 4'h1;
                    nxt_tx = {tx_ff[6:0], 1'b0};
                    nxt_oe = ~tx_ff[6];
                    if (cnt_ff == BITS_LAST) begin
                        nxt_cnt = 4'h0;
                        nxt_oe = 1'b0; // Release for the host's ack
                        nxt_state = ST_RACK;
                    end
                end
            end
            ST_RACK: begin
                if (scl_rise) begin
                    nxt_mack = ~sda_s2_ff;
                end else if (scl_fall) begin
                    nxt_state = ST_IDLE;
                    if (mack_ff) begin
                        nxt_tx = rd_byte;
                        nxt_oe = ~rd_byte[7];
                        nxt_ptr = ptr_ff + 8'h01; // [RULE_12]
                        nxt_state = ST_RDATA;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Start and stop override any state; a repeated start re-addresses
        if (bus_start) begin
            nxt_state = ST_ADDR; // [RULE_11]
            nxt_cnt = 4'h0;
            nxt_oe = 1'b0;
            nxt_mack = 1'b0;
        end else if (bus_stop) begin
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
        end
    end

    // Serial slave state registers; the pointer survives a stop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            shreg_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            mack_ff <= 1'b0;
            oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            shreg_ff <= nxt_shreg;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            mack_ff <= nxt_mack;
            oe_ff <= nxt_oe;
            sda_out_ff <= 1'b0; // Open drain: only ever pulls low
        end
    end

    assign sda_out = sda_out_ff;
    assign sda_oe = oe_ff;
    assign freq_sel = freq_ff;

    // Emitter drive follows the stored frequency code
    lpr_ir_gen u_ir_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(prox_active), // [RULE_08]
        .freq_sel(freq_ff),
        .ir_drive(ir_drive)
    );
endmodule // lpr_result_regs

// ---- lpr_pkg.sv ----
// Package: constants, states and carriers of the light/proximity result bank
package lpr_pkg;
    // Two-wire bus address of the device (write 26h, read 27h)
    localparam logic [6:0] DEV_ADDR = 7'h13;

    // Register addresses
    localparam logic [7:0] REG_AMB_HI = 8'h85;
    localparam logic [7:0] REG_AMB_LO = 8'h86;
    localparam logic [7:0] REG_PROX_HI = 8'h87;
    localparam logic [7:0] REG_PROX_LO = 8'h88;
    localparam logic [7:0] REG_FREQ = 8'h89;

    // Frequency select field layout and reset code
    localparam int FREQ_LSB = 0;
    localparam int FREQ_W = 2;
    localparam logic [1:0] FREQ_RST = 2'h2;
    localparam logic [7:0] RD_NONE = 8'h00;

    // Bus transfer widths
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam logic [3:0] BITS_LAST = 4'h7;

    // Result channels
    localparam int CH_AMB = 0;
    localparam int CH_PROX = 1;
    localparam int N_CH = 2;

    // System clock and infrared test frequencies, in Hz
    localparam int CLK_HZ = 50_000_000;
    localparam int FREQ_HZ_0 = 3_125_000;
    localparam int FREQ_HZ_1 = 1_562_500;
    localparam int FREQ_HZ_2 = 781_250;
    localparam int FREQ_HZ_3 = 390_625;

    // Half periods in system clock cycles
    localparam int HALF_W = 7;
    localparam logic [6:0] HALF_0 = 7'(CLK_HZ / (2 * FREQ_HZ_0));
    localparam logic [6:0] HALF_1 = 7'(CLK_HZ / (2 * FREQ_HZ_1));
    localparam logic [6:0] HALF_2 = 7'(CLK_HZ / (2 * FREQ_HZ_2));
    localparam logic [6:0] HALF_3 = 7'(CLK_HZ / (2 * FREQ_HZ_3));

    // Serial slave states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_REG = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } lpr_state_e;

    // One finished measurement: value with a one-cycle valid
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } lpr_meas_s;
endpackage

// ---- lpr_ir_gen.sv ----
// Square-wave infrared emitter drive at the selected test frequency
`timescale 1ns/1ps
module lpr_ir_gen
    import lpr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] freq_sel,
    output logic ir_drive
);
    logic [HALF_W-1:0] cnt_ff;
    logic [HALF_W-1:0] half;
    logic wave_ff;
    logic last;

    // Half-period lookup from the frequency code [RULE_09]
    assign half = (freq_sel == 2'h0) ? HALF_0 :
                  (freq_sel == 2'h1) ? HALF_1 :
                  (freq_sel == 2'h2) ? HALF_2 : HALF_3;
    assign last = (cnt_ff >= half - 7'h01);
    assign ir_drive = wave_ff;

    // Toggle every half period; idle low so the emitter is dark outside
    // a proximity measurement. A code change takes effect at once. [RULE_08]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 7'h00;
            wave_ff <= 1'b0;
        end else if (!enable) begin
            cnt_ff <= 7'h00;
            wave_ff <= 1'b0;
        end else if (last) begin
            cnt_ff <= 7'h00;
            wave_ff <= ~wave_ff;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end
endmodule // lpr_ir_gen

// ---- lpr_host.sv ----
// Two-wire bus host model for the result bank
`timescale 1ns/1ps
module lpr_host (
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter of the 160 ns bit, moved on falling system edges
    task automatic q();
        repeat (2) @(negedge clk_sys);
    endtask
    // Start or repeated start before a read
    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    // Data changes only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_low = ~b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    // One byte MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic ra);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], t);
            r[i] = t;
        end
        bit_x(a, ra);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
endmodule // lpr_host

// ---- lpr_result_regs_checker.sv ----
// Port assertions of the result bank
`timescale 1ns/1ps
module lpr_result_regs_checker
    import lpr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire lpr_meas_s amb_meas,
    input wire lpr_meas_s prox_meas,
    input wire logic prox_active,
    input wire logic ir_drive,
    input wire logic [1:0] freq_sel
);
    logic [7:0] cnt_ff;
    logic last_ff;
    logic armed_ff;
    wire toggled = ir_drive != last_ff;
    wire [7:0] half = 8'h08 << freq_sel;
    // Cycles since the last emitter edge; the first edge after enable
    // is not judged, only whole half periods
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            last_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            last_ff <= ir_drive;
            cnt_ff <= (toggled || !prox_active) ? 8'h01 : cnt_ff + 8'h01;
            armed_ff <= prox_active && (armed_ff || toggled);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ir_off_a: assert property (!prox_active |=> !ir_drive)
        else $error("emitter on while idle");
    ir_period_a: assert property (
        prox_active && armed_ff && toggled |-> cnt_ff == half)
        else $error("emitter half period wrong");
    ir_start_a: assert property (
        $rose(prox_active) |-> !ir_drive [*6])
        else $error("emitter toggled too early");
    ir_cause_a: assert property (ir_drive |-> $past(prox_active))
        else $error("emitter high without measurement");
    rst_vals_a: assert property (
        $rose(rst_n) |-> freq_sel == FREQ_RST && !sda_oe)
        else $error("reset values wrong");
    oe_scl_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("data changed with clock high");
    sda_zero_a: assert property (sda_out == 1'b0)
        else $error("data driven high");
    ack_len_a: assert property ($rose(sda_oe) |-> sda_oe [*5])
        else $error("driven bit too short");
endmodule // lpr_result_regs_checker

// ---- lpr_result_regs_tb.sv ----
// Testbench of the light and proximity result bank
`timescale 1ns/1ps
module lpr_result_regs_tb;
    import lpr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sda_out, sda_oe, ir_drive, scl, host_low, ack;
    logic [1:0] freq_sel;
    logic prox_active = 1'b0;
    lpr_meas_s amb_meas = '0;
    lpr_meas_s prox_meas = '0;
    logic [7:0] rd, rb;
    logic [15:0] va, vp;
    integer seed = 32'h1c6eb1e6;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    // Pulled-up wire, low when either side pulls
    wire sda = ~(host_low | (sda_oe & ~sda_out));
    always #10 clk_sys = ~clk_sys;
    lpr_host i_host (.clk_sys(clk_sys), .sda(sda), .scl(scl),
                     .sda_low(host_low));
    lpr_result_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .amb_meas(amb_meas), .prox_meas(prox_meas),
        .prox_active(prox_active), .ir_drive(ir_drive),
        .freq_sel(freq_sel));
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A hung bus wait ends the run as a mismatch
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    // Pointer set, then a repeated start for reads
    task automatic addr(input logic [7:0] a, input logic rdm);
        i_host.start();
        i_host.xfer({DEV_ADDR, 1'b0}, 1'b1, rd, ack);
        chk("ack", 8'h00, {7'h0, ack});
        i_host.xfer(a, 1'b1, rd, ack);
        chk("ack", 8'h00, {7'h0, ack});
        if (rdm) begin
            i_host.start();
            i_host.xfer({DEV_ADDR, 1'b1}, 1'b1, rd, ack);
            chk("ack", 8'h00, {7'h0, ack});
        end
    endtask
    task automatic rd_q(input logic [7:0] a, input logic [7:0] e[$]);
        addr(a, 1'b1);
        foreach (e[i]) begin
            i_host.xfer(8'hff, i == e.size() - 1, rd, ack);
            chk("read", e[i], rd);
        end
        i_host.stop();
    endtask
    task automatic wr_q(input logic [7:0] a, input logic [7:0] d[$]);
        addr(a, 1'b0);
        // Writes are acked even where the register ignores them
        foreach (d[i]) begin
            i_host.xfer(d[i], 1'b1, rd, ack);
            chk("wr ack", 8'h00, {7'h0, ack});
        end
        i_host.stop();
    endtask
    // Falling-edge count until the emitter next changes
    task automatic per(output int c);
        logic l;
        l = ir_drive;
        c = 0;
        while (ir_drive === l && c < 200) begin
            @(negedge clk_sys);
            c++;
        end
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("freq_sel", {6'h0, FREQ_RST}, {6'h0, freq_sel});
        rd_q(REG_FREQ, '{{6'h0, FREQ_RST}});
        i_host.start();
        i_host.xfer(8'h50, 1'b1, rd, ack);
        chk("nack", 8'h01, {7'h0, ack});
        i_host.stop();
        rd_q(8'h90, '{RD_NONE});
        // Pointer set, then stop and a fresh start: the pointer must survive
        addr(REG_FREQ, 1'b0);
        i_host.stop();
        i_host.start();
        i_host.xfer({DEV_ADDR, 1'b1}, 1'b1, rd, ack);
        chk("ack", 8'h00, {7'h0, ack});
        i_host.xfer(8'hff, 1'b1, rd, ack);
        chk("read", {6'h0, FREQ_RST}, rd);
        i_host.stop();
        // Back-to-back results: the later one must win in both bytes
        for (int k = 0; k < 3; k++) begin
            va = (k == 0) ? 16'hff00 : 16'($random(seed));
            vp = (k == 0) ? 16'h00ff : 16'($random(seed));
            rb = 8'($random(seed));
            amb_meas = {1'b1, ~va};
            prox_meas = {1'b1, ~vp};
            @(negedge clk_sys);
            amb_meas = {1'b1, va};
            prox_meas = {1'b1, vp};
            @(negedge clk_sys);
            amb_meas.valid = 1'b0;
            prox_meas.valid = 1'b0;
            wr_q(REG_AMB_HI, '{rb, ~rb, rb, ~rb});
            rd_q(REG_AMB_HI,
                 '{va[15:8], va[7:0], vp[15:8], vp[7:0]});
        end
        for (int c = 0; c < 4; c++) begin
            wr_q(REG_FREQ, '{{6'($random(seed)), 2'(c)}});
            rd_q(REG_FREQ, '{{6'h0, 2'(c)}});
            chk("freq_sel", 8'(c), {6'h0, freq_sel});
            prox_active = 1'b1;
            per(n);
            per(n);
            chk("half", 8'(8 << c), 8'(n));
            prox_active = 1'b0;
            @(negedge clk_sys);
            chk("ir idle", 8'h00, {7'h0, ir_drive});
        end
        // Mid-run reset with code 11 stored: the default must come back
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("freq_sel", {6'h0, FREQ_RST}, {6'h0, freq_sel});
        rd_q(REG_FREQ, '{{6'h0, FREQ_RST}});
        end_of_test();
    end
endmodule // lpr_result_regs_tb
bind lpr_result_regs lpr_result_regs_checker i_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .amb_meas(amb_meas), .prox_meas(prox_meas),
    .prox_active(prox_active), .ir_drive(ir_drive), .freq_sel(freq_sel));
